// File: pkg/rssa_defines.svh
/*
 * Constants of the rotate, subtract, skip and set datapath: widths,
 * flag positions, reset values and cycle counts.
 * Assumes it is included by bare name wherever these values are needed.
 */
// Contract
// - Memory rotate-left via carry, only carry changes
// - Accumulator rotate-left via carry, memory kept
// - Memory plain rotate-right, no flag changes
// - Accumulator plain rotate-right, memory, flags kept
// - Memory rotate-right via carry, only carry changes
// - Accumulator rotate-right via carry, memory kept
// - Borrow subtract: acc plus inverted mem plus carry
// - Memory subtract: acc plus inverted mem plus one
// - Immediate subtract into accumulator, four flags
// - Decrement to memory, skip on zero, two cycles when skipping
// - Decrement to accumulator, skip on zero
// - Increment to memory, skip on zero, two cycles when skipping
// - Increment to accumulator, skip on zero
// - Byte set writes all ones, flags kept
// - Bit set touches selected bit only
// - Skip when selected bit is one
// - Memory nibble swap, flags kept
// - Accumulator nibble swap, memory kept
`ifndef RSSA_DEFINES_SVH
`define RSSA_DEFINES_SVH

// ****************************************************************
// Widths and values
// ****************************************************************
`define RSSA_DATA_W      8
`define RSSA_BIT_SEL_W   3
`define RSSA_FLAGS_W     4
`define RSSA_ALL_ONES    8'hff
`define RSSA_ONE         8'h01
`define RSSA_ZERO        8'h00
`define RSSA_ACC_RST     8'h00
`define RSSA_FLAGS_RST   4'h0

// ****************************************************************
// Flag positions within the flag vector
// ****************************************************************
`define RSSA_FLAG_C      0
`define RSSA_FLAG_AC     1
`define RSSA_FLAG_Z      2
`define RSSA_FLAG_OV     3

// ****************************************************************
// Machine cycles per instruction
// ****************************************************************
`define RSSA_PLAIN_CYCLES 1
`define RSSA_SKIP_CYCLES  2

`endif

// File: pkg/rssa_pkg.sv
/*
 * Types of the rotate, subtract, skip and set datapath.
 * Assumes rssa_defines.svh is on the include path.
 */
`include "rssa_defines.svh"

package rssa_pkg;

    // ****************************************************************
    // Instruction group executed by the datapath
    // ****************************************************************
    typedef enum logic [4:0] {
        rotate_left_via_carry_mem,
        rotate_left_via_carry_to_accum,
        rotate_right_in_place,
        rotate_right_to_accum,
        rotate_right_via_carry_mem,
        rotate_right_via_carry_to_accum,
        minus_with_borrow_to_accum,
        minus_with_borrow_to_mem,
        minus_to_accum,
        minus_to_mem,
        minus_imm_to_accum,
        decrement_skip_zero,
        decrement_to_accum_skip_zero,
        increment_skip_zero,
        increment_to_accum_skip_zero,
        set_byte_mem,
        set_bit_mem,
        skip_bit_nonzero,
        nibble_exchange_mem,
        nibble_exchange_to_accum
    } rssa_op_t;

    // Shifter modes
    typedef enum logic [2:0] {
        RSSA_SH_PASS,
        RSSA_SH_RL_C,
        RSSA_SH_RR,
        RSSA_SH_RR_C,
        RSSA_SH_SWAP
    } rssa_shift_t;

    // Execution states
    typedef enum logic {
        RSSA_ST_RUN,
        RSSA_ST_DUMMY
    } rssa_state_t;

endpackage : rssa_pkg

// File: design/rssa_shifter.sv
/*
 * Combinational rotate and nibble-swap unit.
 * Assumes the caller selects the mode and supplies the current carry.
 */
`timescale 1ns/1ps
`include "rssa_defines.svh"

module rssa_shifter
    import rssa_pkg::*;
(
    // Operand
    input  wire logic [`RSSA_DATA_W-1:0] data_in,
    input  wire logic                    carry_in,
    input  wire rssa_shift_t             mode_in,
    // Result
    output logic      [`RSSA_DATA_W-1:0] data_out,
    output logic                         carry_out
);

    always_comb begin
        data_out  = data_in;
        carry_out = carry_in;
        case (mode_in)
            RSSA_SH_RL_C: begin
                data_out  = {data_in[6:0], carry_in};
                carry_out = data_in[7];
            end
            // Bit 0 wraps to bit 7
            RSSA_SH_RR: begin
                data_out  = {data_in[0], data_in[7:1]};
            end
            RSSA_SH_RR_C: begin
                data_out  = {carry_in, data_in[7:1]};
                carry_out = data_in[0];
            end
            RSSA_SH_SWAP: begin
                data_out  = {data_in[3:0], data_in[7:4]};
            end
            default: begin
                data_out  = data_in;
                carry_out = carry_in;
            end
        endcase
    end

endmodule : rssa_shifter

// File: design/rssa_cadd.sv
/*
 * Eight-bit adder for the complement-addition form of subtraction.
 * Assumes the caller inverts the subtrahend and supplies the carry-in.
 */
`timescale 1ns/1ps
`include "rssa_defines.svh"

module rssa_cadd
    import rssa_pkg::*;
(
    // Operands
    input  wire logic [`RSSA_DATA_W-1:0] a_in,
    input  wire logic [`RSSA_DATA_W-1:0] b_in,
    input  wire logic                    cin_in,
    // Sum and flags
    output logic      [`RSSA_DATA_W-1:0] sum_out,
    output logic                         carry_out,
    output logic                         half_out,
    output logic                         ovf_out
);

    logic [4:0] low_sum;
    logic [8:0] full_sum;

    // Carry out of bit 3 and bit 7
    always_comb begin
        low_sum   = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
        full_sum  = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
        sum_out   = full_sum[7:0];
        carry_out = full_sum[8];
        half_out  = low_sum[4];
        ovf_out   = (a_in[7] == b_in[7]) && (full_sum[7] != a_in[7]);
    end

endmodule : rssa_cadd

// File: design/rssa_alu.sv
/*
 * Execution datapath for rotates, subtracts, skip tests, sets and swaps.
 * Holds the accumulator and the OV, Z, AC and C flags; writes results
 * back to data memory through a one-cycle write strobe.
 * Assumes the sequencer presents the memory operand already read, keeps
 * the request for one cycle while ready is high, and discards its
 * prefetched instruction when the skip pulse appears.
 */
`timescale 1ns/1ps
`include "rssa_defines.svh"

module rssa_alu
    import rssa_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    // Instruction request
    input  wire logic                     op_valid_in,
    input  wire rssa_op_t                 op_code_in,
    input  wire logic [`RSSA_DATA_W-1:0]  mem_rdata_in,
    input  wire logic [`RSSA_DATA_W-1:0]  imm_in,
    input  wire logic [`RSSA_BIT_SEL_W-1:0] bit_sel_in,
    // Loads from the rest of the core
    input  wire logic                     acc_load_in,
    input  wire logic [`RSSA_DATA_W-1:0]  acc_load_data_in,
    input  wire logic                     flags_load_in,
    input  wire logic [`RSSA_FLAGS_W-1:0] flags_load_data_in,
    // Sequencer handshake
    output logic                          ready_out,
    output logic                          done_out,
    output logic                          skip_out,
    // Data memory write
    output logic                          mem_we_out,
    output logic      [`RSSA_DATA_W-1:0]  mem_wdata_out,
    // Architectural state
    output logic      [`RSSA_DATA_W-1:0]  acc_out,
    output logic      [`RSSA_FLAGS_W-1:0] flags_out
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    rssa_state_t              state_r;
    logic [`RSSA_DATA_W-1:0]  acc_r;
    logic [`RSSA_FLAGS_W-1:0] flags_r;
    logic                     ready_r;
    logic                     done_r;
    logic                     skip_r;
    logic                     mem_we_r;
    logic [`RSSA_DATA_W-1:0]  mem_wdata_r;

    // ****************************************************************
    // Decode results
    // ****************************************************************
    logic                     take;
    rssa_shift_t              shift_mode;
    logic [`RSSA_DATA_W-1:0]  shift_res;
    logic                     shift_carry;
    logic [`RSSA_DATA_W-1:0]  add_a;
    logic [`RSSA_DATA_W-1:0]  add_b;
    logic                     add_cin;
    logic [`RSSA_DATA_W-1:0]  add_sum;
    logic                     add_carry;
    logic                     add_half;
    logic                     add_ovf;
    logic [`RSSA_DATA_W-1:0]  bit_mask;
    logic [`RSSA_DATA_W-1:0]  res_nxt;
    logic                     to_mem;
    logic                     to_acc;
    logic                     upd_carry;
    logic                     upd_arith;
    logic                     skip_nxt;
    logic [`RSSA_FLAGS_W-1:0] flags_nxt;

    assign take = op_valid_in && ready_r;

    // ****************************************************************
    // Rotate and swap unit
    // ****************************************************************
    always_comb begin
        case (op_code_in)
            rotate_left_via_carry_mem,
            rotate_left_via_carry_to_accum:  shift_mode = RSSA_SH_RL_C;
            rotate_right_in_place,
            rotate_right_to_accum:           shift_mode = RSSA_SH_RR;
            rotate_right_via_carry_mem,
            rotate_right_via_carry_to_accum: shift_mode = RSSA_SH_RR_C;
            nibble_exchange_mem,
            nibble_exchange_to_accum:        shift_mode = RSSA_SH_SWAP;
            default:                         shift_mode = RSSA_SH_PASS;
        endcase
    end

    rssa_shifter u_shifter (
        .data_in   (mem_rdata_in),
        .carry_in  (flags_r[`RSSA_FLAG_C]),
        .mode_in   (shift_mode),
        .data_out  (shift_res),
        .carry_out (shift_carry)
    );

    // ****************************************************************
    // Adder operand selection
    // ****************************************************************
    always_comb begin
        add_a   = acc_r;
        add_b   = ~mem_rdata_in;
        add_cin = 1'b1;
        case (op_code_in)
            // Carry in is the old carry
            minus_with_borrow_to_accum,
            minus_with_borrow_to_mem: begin
                add_cin = flags_r[`RSSA_FLAG_C];
            end
            minus_imm_to_accum: begin
                add_b = ~imm_in;
            end
            // Decrement: memory plus all ones
            decrement_skip_zero,
            decrement_to_accum_skip_zero: begin
                add_a   = mem_rdata_in;
                add_b   = `RSSA_ALL_ONES;
                add_cin = 1'b0;
            end
            // Increment: memory plus zero plus one
            increment_skip_zero,
            increment_to_accum_skip_zero: begin
                add_a   = mem_rdata_in;
                add_b   = `RSSA_ZERO;
                add_cin = 1'b1;
            end
            default: begin
                add_a   = acc_r;
                add_b   = ~mem_rdata_in;
                add_cin = 1'b1;
            end
        endcase
    end

    rssa_cadd u_cadd (
        .a_in      (add_a),
        .b_in      (add_b),
        .cin_in    (add_cin),
        .sum_out   (add_sum),
        .carry_out (add_carry),
        .half_out  (add_half),
        .ovf_out   (add_ovf)
    );

    // ****************************************************************
    // Result routing
    // ****************************************************************
    always_comb begin
        bit_mask  = `RSSA_ONE << bit_sel_in;
        res_nxt   = shift_res;
        to_mem    = 1'b0;
        to_acc    = 1'b0;
        upd_carry = 1'b0;
        upd_arith = 1'b0;
        skip_nxt  = 1'b0;
        case (op_code_in)
            rotate_left_via_carry_mem: begin
                to_mem    = 1'b1;
                upd_carry = 1'b1;
            end
            rotate_left_via_carry_to_accum: begin
                to_acc    = 1'b1;
                upd_carry = 1'b1;
            end
            rotate_right_in_place: begin
                to_mem = 1'b1;
            end
            rotate_right_to_accum: begin
                to_acc = 1'b1;
            end
            rotate_right_via_carry_mem: begin
                to_mem    = 1'b1;
                upd_carry = 1'b1;
            end
            rotate_right_via_carry_to_accum: begin
                to_acc    = 1'b1;
                upd_carry = 1'b1;
            end
            minus_with_borrow_to_accum: begin
                res_nxt   = add_sum;
                to_acc    = 1'b1;
                upd_arith = 1'b1;
            end
            minus_with_borrow_to_mem: begin
                res_nxt   = add_sum;
                to_mem    = 1'b1;
                upd_arith = 1'b1;
            end
            minus_to_accum: begin
                res_nxt   = add_sum;
                to_acc    = 1'b1;
                upd_arith = 1'b1;
            end
            minus_to_mem: begin
                res_nxt   = add_sum;
                to_mem    = 1'b1;
                upd_arith = 1'b1;
            end
            minus_imm_to_accum: begin
                res_nxt   = add_sum;
                to_acc    = 1'b1;
                upd_arith = 1'b1;
            end
            decrement_skip_zero: begin
                res_nxt  = add_sum;
                to_mem   = 1'b1;
                skip_nxt = (add_sum == `RSSA_ZERO);
            end
            decrement_to_accum_skip_zero: begin
                res_nxt  = add_sum;
                to_acc   = 1'b1;
                skip_nxt = (add_sum == `RSSA_ZERO);
            end
            increment_skip_zero: begin
                res_nxt  = add_sum;
                to_mem   = 1'b1;
                skip_nxt = (add_sum == `RSSA_ZERO);
            end
            increment_to_accum_skip_zero: begin
                res_nxt  = add_sum;
                to_acc   = 1'b1;
                skip_nxt = (add_sum == `RSSA_ZERO);
            end
            set_byte_mem: begin
                res_nxt = `RSSA_ALL_ONES;
                to_mem  = 1'b1;
            end
            set_bit_mem: begin
                res_nxt = mem_rdata_in | bit_mask;
                to_mem  = 1'b1;
            end
            skip_bit_nonzero: begin
                res_nxt  = mem_rdata_in;
                skip_nxt = |(mem_rdata_in & bit_mask);
            end
            nibble_exchange_mem: begin
                to_mem = 1'b1;
            end
            nibble_exchange_to_accum: begin
                to_acc = 1'b1;
            end
            default: begin
                res_nxt = shift_res;
            end
        endcase
    end

    // ****************************************************************
    // Flag update
    // ****************************************************************
    always_comb begin
        flags_nxt = flags_r;
        if (upd_carry) begin
            flags_nxt[`RSSA_FLAG_C] = shift_carry;
        end
        if (upd_arith) begin
            flags_nxt[`RSSA_FLAG_C]  = add_carry;
            flags_nxt[`RSSA_FLAG_AC] = add_half;
            flags_nxt[`RSSA_FLAG_Z]  = (add_sum == `RSSA_ZERO);
            flags_nxt[`RSSA_FLAG_OV] = add_ovf;
        end
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    // Skip inserts one dummy cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r <= RSSA_ST_RUN;
            ready_r <= 1'b1;
        end else begin
            case (state_r)
                RSSA_ST_RUN: begin
                    if (take && skip_nxt) begin
                        state_r <= RSSA_ST_DUMMY;
                        ready_r <= 1'b0;
                    end
                end
                RSSA_ST_DUMMY: begin
                    state_r <= RSSA_ST_RUN;
                    ready_r <= 1'b1;
                end
                default: begin
                    state_r <= RSSA_ST_RUN;
                    ready_r <= 1'b1;
                end
            endcase
        end
    end

    // Completion and discard pulses
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            done_r <= take;
            skip_r <= take && skip_nxt;
        end
    end

    // ****************************************************************
    // Memory write port
    // ****************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mem_we_r    <= 1'b0;
            mem_wdata_r <= `RSSA_ZERO;
        end else begin
            mem_we_r <= take && to_mem;
            if (take && to_mem) begin
                mem_wdata_r <= res_nxt;
            end
        end
    end

    // ****************************************************************
    // Accumulator and flags
    // ****************************************************************
    // Own results win over loads from the core
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            acc_r <= `RSSA_ACC_RST;
        end else if (take && to_acc) begin
            acc_r <= res_nxt;
        end else if (acc_load_in) begin
            acc_r <= acc_load_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flags_r <= `RSSA_FLAGS_RST;
        end else if (take && (upd_carry || upd_arith)) begin
            flags_r <= flags_nxt;
        end else if (flags_load_in) begin
            flags_r <= flags_load_data_in;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign ready_out     = ready_r;
    assign done_out      = done_r;
    assign skip_out      = skip_r;
    assign mem_we_out    = mem_we_r;
    assign mem_wdata_out = mem_wdata_r;
    assign acc_out       = acc_r;
    assign flags_out     = flags_r;

endmodule : rssa_alu

// File: verification/rssa_alu_properties.sv
/*
 * Checker for the rotate, subtract, skip and set datapath.
 * Assumes it is bound to rssa_alu and sees only that module's ports.
 */
`timescale 1ns/1ps

module rssa_alu_properties
    import rssa_pkg::*;
(
    // Clock, reset and request
    input wire logic       clock_in,
    input wire logic       rst_in,
    input wire logic       op_valid_in,
    input wire rssa_op_t   op_code_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic       acc_load_in,
    input wire logic       flags_load_in,
    // Results
    input wire logic       ready_out,
    input wire logic       done_out,
    input wire logic       skip_out,
    input wire logic       mem_we_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic [7:0] acc_out,
    input wire logic [3:0] flags_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // ****
    // Request taken with no external load competing
    // ****
    wire take = op_valid_in && ready_out && !acc_load_in && !flags_load_in;

    sequence dummy_cycle;
        !ready_out ##1 ready_out;
    endsequence

    a_done_after_take: assert property (op_valid_in && ready_out |=> done_out)
        else $error("no done after a taken request");
    a_skip_then_dummy: assert property (skip_out |-> dummy_cycle)
        else $error("skip without one dummy cycle");
    a_rl_via_carry: assert property (take && op_code_in == rotate_left_via_carry_mem |=>
        mem_we_out && mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(flags_out[0])}
        && flags_out == {$past(flags_out[3:1]), $past(mem_rdata_in[7])})
        else $error("rotate left via carry wrong");
    a_rr_accum: assert property (take && op_code_in == rotate_right_to_accum |=>
        !mem_we_out && $stable(flags_out)
        && acc_out == {$past(mem_rdata_in[0]), $past(mem_rdata_in[7:1])})
        else $error("rotate right to accumulator wrong");
    a_sub_no_borrow: assert property (take && op_code_in == minus_to_accum |=>
        acc_out == $past(acc_out - mem_rdata_in)
        && flags_out[0] == $past(acc_out >= mem_rdata_in))
        else $error("subtract result or carry wrong");
    a_dec_skip_zero: assert property (take && op_code_in == decrement_skip_zero |=>
        mem_we_out && mem_wdata_out == $past(mem_rdata_in - 8'h01)
        && skip_out == $past(mem_rdata_in == 8'h01))
        else $error("decrement skip wrong");
    a_set_byte_ones: assert property (take && op_code_in == set_byte_mem |=>
        mem_we_out && mem_wdata_out == 8'hff && $stable(flags_out))
        else $error("byte set wrong");
    a_bit_skip_test: assert property (take && op_code_in == skip_bit_nonzero |=>
        !mem_we_out && skip_out == $past(mem_rdata_in[bit_sel_in]))
        else $error("bit skip wrong");
    a_swap_accum: assert property (take && op_code_in == nibble_exchange_to_accum |=>
        !mem_we_out && acc_out == {$past(mem_rdata_in[3:0]), $past(mem_rdata_in[7:4])})
        else $error("nibble swap to accumulator wrong");
endmodule : rssa_alu_properties

// File: verification/rssa_mem_model.sv
/*
 * Data memory byte seen by the datapath.
 * Assumes writes arrive as a one-cycle strobe and the bench presets it.
 */
`timescale 1ns/1ps

module rssa_mem_model (
    // Clock and control
    input  wire logic       clock_in,
    input  wire logic       preset_in,
    input  wire logic [7:0] preset_data_in,
    input  wire logic       valid_in,
    // Datapath side
    input  wire logic       we_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out
);
    logic [7:0] mem_r;

    always_ff @(posedge clock_in) begin
        if (preset_in) begin
            mem_r <= preset_data_in;
        end else if (we_in) begin
            mem_r <= wdata_in;
        end
    end

    // Operand is only good while a request stands
    assign rdata_out = valid_in ? mem_r : ~mem_r;
endmodule : rssa_mem_model

// File: verification/testbench.sv
/*
 * Self-checking bench for the datapath.
 * Assumes the package, design and memory model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end

module testbench;
    import rssa_pkg::*;
    logic       clock_in, rst_in, op_valid_in, acc_load_in, flags_load_in, preset;
    logic       ready_out, done_out, skip_out, mem_we_out;
    logic [7:0] mem_rdata_in, imm_in, acc_load_data_in, preset_data, mem_wdata_out, acc_out;
    logic [3:0] flags_load_data_in, flags_out;
    logic [2:0] bit_sel_in;
    rssa_op_t   op_code_in;
    int         miscompares, n_compared, cycles;

    rssa_alu rssa_alu_inst (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .mem_rdata_in(mem_rdata_in), .imm_in(imm_in),
        .bit_sel_in(bit_sel_in), .acc_load_in(acc_load_in), .acc_load_data_in(acc_load_data_in),
        .flags_load_in(flags_load_in), .flags_load_data_in(flags_load_data_in),
        .ready_out(ready_out), .done_out(done_out), .skip_out(skip_out),
        .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
        .flags_out(flags_out));
    rssa_mem_model rssa_mem_model_inst (.clock_in(clock_in), .preset_in(preset),
        .preset_data_in(preset_data), .valid_in(op_valid_in), .we_in(mem_we_out),
        .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ****
    // Load state, issue one request, judge the answer
    // ****
    task automatic step(input rssa_op_t op, input logic [7:0] m, input logic [3:0] fl,
                        input logic we, input logic [7:0] r, input logic [3:0] fx,
                        input logic [7:0] a = 8'h77, input logic sk = 1'b0,
                        input logic [2:0] bs = 3'h0);
        @(posedge clock_in); #5;
        {acc_load_in, flags_load_in, preset} = 3'h7;
        acc_load_data_in = a;
        flags_load_data_in = fl;
        preset_data = m;
        @(posedge clock_in); #5;
        {acc_load_in, flags_load_in, preset} = 3'h0;
        op_valid_in = 1'b1;
        op_code_in = op;
        imm_in = ~m;
        bit_sel_in = bs;
        @(posedge clock_in); #5;
        op_valid_in = sk;
        `CHK(done_out, 1'b1)
        `CHK(mem_we_out, we)
        if (we) `CHK(mem_wdata_out, r)
        `CHK(acc_out, we ? a : r)
        `CHK(flags_out, fx)
        `CHK(skip_out, sk)
        `CHK(ready_out, !sk)
        if (sk) begin
            @(posedge clock_in); #5;
            op_valid_in = 1'b0;
            `CHK(done_out, 1'b0)
            `CHK(ready_out, 1'b1)
        end
    endtask : step

    task automatic t_rotates;
        step(rotate_left_via_carry_mem, 8'h96, 4'ha, 1'b1, 8'h2c, 4'hb);
        step(rotate_left_via_carry_to_accum, 8'h96, 4'ha, 1'b0, 8'h2c, 4'hb);
        step(rotate_right_in_place, 8'h96, 4'ha, 1'b1, 8'h4b, 4'ha);
        step(rotate_right_to_accum, 8'h96, 4'ha, 1'b0, 8'h4b, 4'ha);
        step(rotate_right_via_carry_mem, 8'h96, 4'h5, 1'b1, 8'hcb, 4'h4);
        step(rotate_right_via_carry_to_accum, 8'h96, 4'h5, 1'b0, 8'hcb, 4'h4);
    endtask : t_rotates

    task automatic t_subtracts;
        step(minus_with_borrow_to_accum, 8'h03, 4'h0, 1'b0, 8'h01, 4'h3, 8'h05);
        step(minus_with_borrow_to_mem, 8'h01, 4'h1, 1'b1, 8'h7f, 4'h9, 8'h80);
        step(minus_to_accum, 8'h03, 4'h0, 1'b0, 8'h00, 4'h7, 8'h03);
        step(minus_to_mem, 8'h05, 4'hf, 1'b1, 8'hfe, 4'h0, 8'h03);
        step(minus_imm_to_accum, 8'hfe, 4'h0, 1'b0, 8'h0f, 4'h1, 8'h10);
    endtask : t_subtracts

    task automatic t_skips;
        step(decrement_skip_zero, 8'h01, 4'hf, 1'b1, 8'h00, 4'hf, 8'h77, 1'b1);
        step(decrement_skip_zero, 8'h00, 4'h6, 1'b1, 8'hff, 4'h6);
        step(decrement_to_accum_skip_zero, 8'h01, 4'h6, 1'b0, 8'h00, 4'h6, 8'h77, 1'b1);
        step(increment_skip_zero, 8'hff, 4'h9, 1'b1, 8'h00, 4'h9, 8'h77, 1'b1);
        step(increment_to_accum_skip_zero, 8'hfe, 4'h9, 1'b0, 8'hff, 4'h9);
        step(skip_bit_nonzero, 8'h08, 4'h5, 1'b0, 8'h77, 4'h5, 8'h77, 1'b1, 3'h3);
        step(skip_bit_nonzero, 8'h08, 4'h5, 1'b0, 8'h77, 4'h5, 8'h77, 1'b0, 3'h2);
    endtask : t_skips

    task automatic t_sets_swaps;
        step(set_byte_mem, 8'h12, 4'ha, 1'b1, 8'hff, 4'ha);
        step(set_bit_mem, 8'h00, 4'h5, 1'b1, 8'h80, 4'h5, 8'h77, 1'b0, 3'h7);
        step(set_bit_mem, 8'hf0, 4'h5, 1'b1, 8'hf1, 4'h5, 8'h77, 1'b0, 3'h0);
        step(nibble_exchange_mem, 8'ha5, 4'hc, 1'b1, 8'h5a, 4'hc);
        step(nibble_exchange_to_accum, 8'h3c, 4'hc, 1'b0, 8'hc3, 4'hc);
    endtask : t_sets_swaps

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        {rst_in, op_valid_in, acc_load_in, flags_load_in, preset} = 5'h10;
        {imm_in, acc_load_data_in, preset_data, flags_load_data_in, bit_sel_in} = '0;
        op_code_in = rotate_left_via_carry_mem;
        repeat (12) @(posedge clock_in);
        #5 rst_in = 1'b0;
        t_rotates();
        t_subtracts();
        t_skips();
        t_sets_swaps();
        give_verdict();
    end
endmodule : testbench

bind rssa_alu rssa_alu_properties rssa_alu_properties_inst (.clock_in(clock_in),
    .rst_in(rst_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .mem_rdata_in(mem_rdata_in), .bit_sel_in(bit_sel_in), .acc_load_in(acc_load_in),
    .flags_load_in(flags_load_in), .ready_out(ready_out), .done_out(done_out),
    .skip_out(skip_out), .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out),
    .acc_out(acc_out), .flags_out(flags_out));
